// *** rtl/tfx_irq_sense.sv ***
// Timer event flags, external interrupt sensing, control register.
// Assumes timer units pulse their events for one clk_i cycle, the core
// pulses ack with the vector it executes, and an APB master.
// Summary of operation
// R1 - Capture event copies wide count into capture register and sets bit 5
// R2 - Timer flags clear on vector execution or on software write of one
// R3 - Capture request needs global enable, capture enable and capture flag
// R4 - Wide count equal to compare A sets bit 4
// R5 - Wide count equal to compare B sets bit 3
// R6 - Wide overflow sets bit 2; in PWM, direction reversal at zero
// R7 - Narrow count equal to its compare sets bit 1
// R8 - Narrow overflow sets bit 0; in PWM, direction reversal at zero
// R9 - Compare and overflow requests need global enable, own enable, flag
// R10 - External pins request even when driven as outputs by the chip
// R11 - Pin two is edge only; pins zero and one also low level
// R12 - Enabled level sensing requests for as long as the pin is low
// R13 - Interrupt one needs global enable and its global control mask bit
// R14 - Pins are sampled before edge detection; longer pulses always count
// R15 - Source holds a low level until the current instruction completes
// R16 - Interrupt one sense: low, any change, falling, rising
// R17 - Control register read/write, resets to zero, fixed field layout
// R18 - Sleep instruction sleeps only while sleep enable is set
// R19 - Software sets sleep enable just before the sleep instruction
// R20 - Sleep mode field decodes six modes and two reserved codes
// R21 - Interrupt zero sense decodes like interrupt one
// R22 - A hardware set beats a same-cycle clear
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tfx_irq_sense
    import tfx_pkg::*;
#(
    parameter int SYNC_STAGES = 3
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // APB slave
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [ADDR_W-1:0]  paddr_i,
    input  wire logic [31:0]        pwdata_i,
    input  wire logic [3:0]         pstrb_i,
    output logic      [31:0]        prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    // Timer units and core
    input  wire tfx_timer_in_t      timer_i,
    input  wire tfx_core_in_t       core_i,
    // External interrupt pins, levels seen at the pads
    input  wire logic [2:0]         ext_irq_pin_i,
    // Requests toward the core, indexed by tfx_vec_t
    output logic [NUM_VEC-1:0]      irq_req_o,
    output logic                    sleep_o,
    output tfx_sleep_t              sleep_mode_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]         mcu_control;
        logic [7:0]         timer_event_flags;
        logic [7:0]         timer_mask;
        logic [7:0]         ext_flags;
        logic [7:0]         global_irq_control;
        logic [15:0]        capture_register;
        logic [SYNC_STAGES-1:0][2:0] sync;
        logic [2:0]         pin_stable;
        logic [NUM_VEC-1:0] irq_req;
        logic               sleep;
        tfx_sleep_t         sleep_mode;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
    } tfx_state_t;

    tfx_state_t s_reg;
    tfx_state_t s_next;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Edge match for a programmable sense field; level mode never matches
    function automatic logic sense_edge(input tfx_sense_t sense,
                                        input logic       prev,
                                        input logic       cur);
        logic hit;
        hit = 1'b0;
        case (sense)
            SENSE_ANY:  hit = prev ^ cur;
            SENSE_FALL: hit = prev & ~cur;
            SENSE_RISE: hit = ~prev & cur;
            default:    hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic idx_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [IDX_W-1:0]  idx);
        return addr[ADDR_W-1:2] == idx;
    endfunction

    // Reserved sleep codes fall back to idle, the lightest mode
    function automatic tfx_sleep_t sleep_decode(input logic [2:0] code);
        tfx_sleep_t m;
        m = SLP_IDLE;
        case (code)
            3'h0:    m = SLP_IDLE;
            3'h1:    m = SLP_NOISE_REDUCE;
            3'h2:    m = SLP_POWER_DOWN;
            3'h3:    m = SLP_POWER_SAVE;
            3'h6:    m = SLP_STANDBY;
            3'h7:    m = SLP_EXT_STANDBY;
            default: m = SLP_IDLE;
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic [7:0]         tmr_set;
    logic [7:0]         tmr_clr;
    logic [7:0]         ext_set;
    logic [7:0]         ext_clr;
    logic [2:0]         pin_prev;
    logic [2:0]         pin_cur;
    logic [2:0]         level_req;
    tfx_sense_t         sense0;
    tfx_sense_t         sense1;
    logic               wr_en;
    logic               setup;
    logic               mapped;
    logic [31:0]        rd_data;
    logic               gie;
    logic               any_req;

    always_comb begin
        s_next   = s_reg;
        tmr_set  = 8'h00;
        tmr_clr  = 8'h00;
        ext_set  = 8'h00;
        ext_clr  = 8'h00;
        rd_data  = 32'h0000_0000;
        mapped   = 1'b0;
        gie      = core_i.global_irq_enable;
        sense0   = tfx_sense_t'(s_reg.mcu_control[POS_IRQ0_SENSE +: 2]);
        sense1   = tfx_sense_t'(s_reg.mcu_control[POS_IRQ1_SENSE +: 2]);

        // --------------------------------------------------------------
        // Pin synchroniser
        // --------------------------------------------------------------
        // R10 The pad level is sampled whatever the pin direction is
        s_next.sync[0] = ext_irq_pin_i;
        for (int i = 1; i < SYNC_STAGES; i++) begin
            s_next.sync[i] = s_reg.sync[i-1];
        end
        // R14 Change accepted once the last two stages agree
        for (int p = 0; p < 3; p++) begin
            if (s_reg.sync[SYNC_STAGES-1][p] ==
                s_reg.sync[SYNC_STAGES-2][p]) begin
                s_next.pin_stable[p] = s_reg.sync[SYNC_STAGES-1][p];
            end
        end
        pin_prev = s_reg.pin_stable;
        pin_cur  = s_next.pin_stable;

        // --------------------------------------------------------------
        // Timer events
        // --------------------------------------------------------------
        // R1 capture copy and flag
        if (timer_i.capture_evt) begin
            s_next.capture_register   = timer_i.wide_count;
            tmr_set[BIT_CAPTURE]      = 1'b1;
        end
        // R4 compare A match
        tmr_set[BIT_WIDE_CMP_A] = timer_i.wide_tick &
            (timer_i.wide_count == timer_i.wide_cmp_a);
        // R5 compare B match
        tmr_set[BIT_WIDE_CMP_B] = timer_i.wide_tick &
            (timer_i.wide_count == timer_i.wide_cmp_b);
        // R6 overflow or bottom turn
        tmr_set[BIT_WIDE_OVF] = timer_i.wide_pwm ? timer_i.wide_bottom
                                                 : timer_i.wide_overflow;
        // R7 narrow compare match
        tmr_set[BIT_NARROW_CMP] = timer_i.narrow_tick &
            (timer_i.narrow_count == timer_i.narrow_cmp);
        // R8 narrow overflow or bottom turn
        tmr_set[BIT_NARROW_OVF] = timer_i.narrow_pwm ? timer_i.narrow_bottom
                                                     : timer_i.narrow_overflow;

        // --------------------------------------------------------------
        // External events
        // --------------------------------------------------------------
        // R21 interrupt zero sense decode
        ext_set[BIT_EXT0] = sense_edge(sense0, pin_prev[0], pin_cur[0]);
        // R16 interrupt one sense decode
        ext_set[BIT_EXT1] = sense_edge(sense1, pin_prev[1], pin_cur[1]);
        // R11 pin two edge only, polarity from external control
        ext_set[BIT_EXT2] = s_reg.global_irq_control[BIT_EXT2_RISING]
                            ? (~pin_prev[2] & pin_cur[2])
                            : (pin_prev[2] & ~pin_cur[2]);
        level_req = {1'b0,
                     (sense1 == SENSE_LOW) & ~pin_cur[1],
                     (sense0 == SENSE_LOW) & ~pin_cur[0]};

        // --------------------------------------------------------------
        // Vector acknowledge
        // --------------------------------------------------------------
        // R2 executed vector clears its flag
        if (core_i.ack) begin
            case (core_i.ack_vec)
                VEC_EXT0:       ext_clr[BIT_EXT0]       = 1'b1;
                VEC_EXT1:       ext_clr[BIT_EXT1]       = 1'b1;
                VEC_EXT2:       ext_clr[BIT_EXT2]       = 1'b1;
                VEC_CAPTURE:    tmr_clr[BIT_CAPTURE]    = 1'b1;
                VEC_WIDE_CMP_A: tmr_clr[BIT_WIDE_CMP_A] = 1'b1;
                VEC_WIDE_CMP_B: tmr_clr[BIT_WIDE_CMP_B] = 1'b1;
                VEC_WIDE_OVF:   tmr_clr[BIT_WIDE_OVF]   = 1'b1;
                VEC_NARROW_CMP: tmr_clr[BIT_NARROW_CMP] = 1'b1;
                VEC_NARROW_OVF: tmr_clr[BIT_NARROW_OVF] = 1'b1;
                default:        tmr_clr                 = 8'h00;
            endcase
        end

        // --------------------------------------------------------------
        // APB slave
        // --------------------------------------------------------------
        // Data is snapshot in the setup cycle; access phase is one cycle
        setup = psel_i & ~penable_i & ~s_reg.pready;
        wr_en = psel_i & penable_i & s_reg.pready & pwrite_i & pstrb_i[0];
        if (idx_hit(paddr_i, IDX_MCU_CONTROL)) begin
            mapped  = 1'b1;
            rd_data = {24'h000000, s_reg.mcu_control};
        end else if (idx_hit(paddr_i, IDX_TIMER_FLAGS)) begin
            mapped  = 1'b1;
            rd_data = {24'h000000, s_reg.timer_event_flags};
        end else if (idx_hit(paddr_i, IDX_TIMER_MASK)) begin
            mapped  = 1'b1;
            rd_data = {24'h000000, s_reg.timer_mask};
        end else if (idx_hit(paddr_i, IDX_EXT_FLAGS)) begin
            mapped  = 1'b1;
            rd_data = {24'h000000, s_reg.ext_flags};
        end else if (idx_hit(paddr_i, IDX_EXT_CONTROL)) begin
            mapped  = 1'b1;
            rd_data = {24'h000000, s_reg.global_irq_control};
        end else if (idx_hit(paddr_i, IDX_CAPTURE)) begin
            mapped  = 1'b1;
            rd_data = {16'h0000, s_reg.capture_register};
        end
        // Misaligned byte addresses are refused as well
        if (paddr_i[1:0] != 2'b00) begin
            mapped = 1'b0;
        end

        if (setup) begin
            s_next.pready  = 1'b1;
            s_next.pslverr = ~mapped;
            s_next.prdata  = mapped ? rd_data : 32'h0000_0000;
        end else if (s_reg.pready) begin
            s_next.pready  = 1'b0;
            s_next.pslverr = 1'b0;
        end

        if (wr_en & mapped) begin
            if (idx_hit(paddr_i, IDX_MCU_CONTROL)) begin
                // R17 full-byte read/write control register
                s_next.mcu_control = pwdata_i[7:0];
            end else if (idx_hit(paddr_i, IDX_TIMER_FLAGS)) begin
                // R2 write one clears
                tmr_clr = tmr_clr | (pwdata_i[7:0] & 8'h3F);
            end else if (idx_hit(paddr_i, IDX_TIMER_MASK)) begin
                s_next.timer_mask = pwdata_i[7:0] & 8'h3F;
            end else if (idx_hit(paddr_i, IDX_EXT_FLAGS)) begin
                ext_clr = ext_clr | (pwdata_i[7:0] & 8'hE0);
            end else if (idx_hit(paddr_i, IDX_EXT_CONTROL)) begin
                s_next.global_irq_control = pwdata_i[7:0] & 8'hE1;
            end
        end

        // --------------------------------------------------------------
        // Flag update
        // --------------------------------------------------------------
        // R22 set terms are ORed after the clear
        s_next.timer_event_flags =
            (s_reg.timer_event_flags & ~tmr_clr) | tmr_set;
        s_next.ext_flags = (s_reg.ext_flags & ~ext_clr) | ext_set;
        // Level mode keeps the flag cleared; the pin itself requests
        if (sense0 == SENSE_LOW) begin
            s_next.ext_flags[BIT_EXT0] = 1'b0;
        end
        if (sense1 == SENSE_LOW) begin
            s_next.ext_flags[BIT_EXT1] = 1'b0;
        end

        // --------------------------------------------------------------
        // Requests
        // --------------------------------------------------------------
        // R3 capture request gating
        s_next.irq_req[VEC_CAPTURE] = gie &
            s_next.timer_mask[BIT_CAPTURE] &
            s_next.timer_event_flags[BIT_CAPTURE];
        // R9 compare and overflow gating
        s_next.irq_req[VEC_WIDE_CMP_A] = gie &
            s_next.timer_mask[BIT_WIDE_CMP_A] &
            s_next.timer_event_flags[BIT_WIDE_CMP_A];
        s_next.irq_req[VEC_WIDE_CMP_B] = gie &
            s_next.timer_mask[BIT_WIDE_CMP_B] &
            s_next.timer_event_flags[BIT_WIDE_CMP_B];
        s_next.irq_req[VEC_WIDE_OVF] = gie &
            s_next.timer_mask[BIT_WIDE_OVF] &
            s_next.timer_event_flags[BIT_WIDE_OVF];
        s_next.irq_req[VEC_NARROW_CMP] = gie &
            s_next.timer_mask[BIT_NARROW_CMP] &
            s_next.timer_event_flags[BIT_NARROW_CMP];
        s_next.irq_req[VEC_NARROW_OVF] = gie &
            s_next.timer_mask[BIT_NARROW_OVF] &
            s_next.timer_event_flags[BIT_NARROW_OVF];
        // R12 level request follows the pin
        s_next.irq_req[VEC_EXT0] = gie &
            s_next.global_irq_control[BIT_EXT0] &
            (s_next.ext_flags[BIT_EXT0] | level_req[0]);
        // R13 interrupt one needs its global control mask bit
        s_next.irq_req[VEC_EXT1] = gie &
            s_next.global_irq_control[BIT_EXT1] &
            (s_next.ext_flags[BIT_EXT1] | level_req[1]);
        s_next.irq_req[VEC_EXT2] = gie &
            s_next.global_irq_control[BIT_EXT2] &
            s_next.ext_flags[BIT_EXT2];

        // --------------------------------------------------------------
        // Sleep
        // --------------------------------------------------------------
        any_req = |s_next.irq_req;
        if (s_reg.sleep & any_req) begin
            s_next.sleep = 1'b0;
        // R18 sleep only with sleep enable set
        end else if (core_i.sleep_instr &
                     s_reg.mcu_control[BIT_SLEEP_ENABLE]) begin
            s_next.sleep      = 1'b1;
            // R20 mode field decode
            s_next.sleep_mode = sleep_decode(
                s_reg.mcu_control[POS_SLEEP_MODE +: 3]);
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg.mcu_control        <= RST_MCU_CONTROL;
            s_reg.timer_event_flags  <= RST_TIMER_FLAGS;
            s_reg.timer_mask         <= RST_TIMER_MASK;
            s_reg.ext_flags          <= RST_EXT_FLAGS;
            s_reg.global_irq_control <= RST_EXT_CONTROL;
            s_reg.capture_register   <= RST_CAPTURE;
            // Pins idle high so no false edge follows reset
            s_reg.sync               <= '1;
            s_reg.pin_stable         <= 3'h7;
            s_reg.irq_req            <= '0;
            s_reg.sleep              <= 1'b0;
            s_reg.sleep_mode         <= SLP_IDLE;
            s_reg.prdata             <= 32'h0000_0000;
            s_reg.pready             <= 1'b0;
            s_reg.pslverr            <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata_o     = s_reg.prdata;
    assign pready_o     = s_reg.pready;
    assign pslverr_o    = s_reg.pslverr;
    assign irq_req_o    = s_reg.irq_req;
    assign sleep_o      = s_reg.sleep;
    assign sleep_mode_o = s_reg.sleep_mode;

endmodule

`default_nettype wire

// *** rtl/tfx_pkg.sv ***
// Package for the timer flag and external interrupt sense block.
// Assumes an APB register bus with 32-bit data and word-aligned registers.
package tfx_pkg;

    // ------------------------------------------------------------------
    // Register map (word index, byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam int          IDX_W           = 10;
    localparam logic [9:0]  IDX_MCU_CONTROL = 10'h037;
    localparam logic [9:0]  IDX_TIMER_FLAGS = 10'h038;
    localparam logic [9:0]  IDX_TIMER_MASK  = 10'h039;
    localparam logic [9:0]  IDX_EXT_FLAGS   = 10'h03A;
    localparam logic [9:0]  IDX_EXT_CONTROL = 10'h03B;
    localparam logic [9:0]  IDX_CAPTURE     = 10'h03C;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_MCU_CONTROL = 8'h00;
    localparam logic [7:0]  RST_TIMER_FLAGS = 8'h00;
    localparam logic [7:0]  RST_TIMER_MASK  = 8'h00;
    localparam logic [7:0]  RST_EXT_FLAGS   = 8'h00;
    localparam logic [7:0]  RST_EXT_CONTROL = 8'h00;
    localparam logic [15:0] RST_CAPTURE     = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // Timer flags and timer mask share one layout
    localparam int BIT_CAPTURE       = 5;
    localparam int BIT_WIDE_CMP_A    = 4;
    localparam int BIT_WIDE_CMP_B    = 3;
    localparam int BIT_WIDE_OVF      = 2;
    localparam int BIT_NARROW_CMP    = 1;
    localparam int BIT_NARROW_OVF    = 0;
    // Control register
    localparam int BIT_SLEEP_ENABLE  = 7;
    localparam int POS_SLEEP_MODE    = 4;
    localparam int POS_IRQ1_SENSE    = 2;
    localparam int POS_IRQ0_SENSE    = 0;
    // External flags and external control share pin positions
    localparam int BIT_EXT1          = 7;
    localparam int BIT_EXT0          = 6;
    localparam int BIT_EXT2          = 5;
    localparam int BIT_EXT2_RISING   = 0;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SENSE_LOW, SENSE_ANY, SENSE_FALL, SENSE_RISE
    } tfx_sense_t;

    typedef enum logic [2:0] {
        SLP_IDLE, SLP_NOISE_REDUCE, SLP_POWER_DOWN, SLP_POWER_SAVE,
        SLP_RESERVED_4, SLP_RESERVED_5, SLP_STANDBY, SLP_EXT_STANDBY
    } tfx_sleep_t;

    typedef enum logic [3:0] {
        VEC_EXT0, VEC_EXT1, VEC_EXT2, VEC_CAPTURE, VEC_WIDE_CMP_A,
        VEC_WIDE_CMP_B, VEC_WIDE_OVF, VEC_NARROW_CMP, VEC_NARROW_OVF
    } tfx_vec_t;

    localparam int NUM_VEC = 9;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        capture_evt;
        logic        wide_tick;
        logic        wide_pwm;
        logic        wide_bottom;
        logic        wide_overflow;
        logic [15:0] wide_count;
        logic [15:0] wide_cmp_a;
        logic [15:0] wide_cmp_b;
        logic        narrow_tick;
        logic        narrow_pwm;
        logic        narrow_bottom;
        logic        narrow_overflow;
        logic [7:0]  narrow_count;
        logic [7:0]  narrow_cmp;
    } tfx_timer_in_t;

    typedef struct packed {
        logic     global_irq_enable;
        logic     ack;
        tfx_vec_t ack_vec;
        logic     sleep_instr;
    } tfx_core_in_t;

endpackage

// *** tb/tfx_irq_sense_assertions.sv ***
// Port checker for the timer flag and pin sense block.
// Assumes it is bound to the block's top module.
`timescale 1ns/1ps
`default_nettype none
module tfx_irq_sense_chk
    import tfx_pkg::*;
(
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               psel_i,
    input wire logic               penable_i,
    input wire logic [ADDR_W-1:0]  paddr_i,
    input wire logic [31:0]        prdata_o,
    input wire logic               pready_o,
    input wire logic               pslverr_o,
    input wire tfx_timer_in_t      timer_i,
    input wire tfx_core_in_t       core_i,
    input wire logic [NUM_VEC-1:0] irq_req_o,
    input wire logic               sleep_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_setup;
        psel_i && !penable_i && !pready_o;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready_o)
        else $error("ready missing after setup");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_misaligned_err: assert property (psel_i && !penable_i && !pready_o
        && paddr_i[1:0] != 2'h0 |=> pslverr_o && prdata_o == 32'h0)
        else $error("misaligned access not refused");
    a_capture_gie: assert property ($rose(irq_req_o[3])
        |-> $past(core_i.global_irq_enable))
        else $error("capture request without enable");
    a_timer_gie: assert property ((|irq_req_o[8:4])
        |-> $past(core_i.global_irq_enable))
        else $error("timer request without enable");
    a_ack_clears: assert property (core_i.ack && core_i.ack_vec ==
        VEC_CAPTURE && !timer_i.capture_evt ##1 1 |-> !irq_req_o[3])
        else $error("capture request survives its ack");
    a_flag_holds: assert property (irq_req_o[3] && !core_i.ack && !psel_i
        && core_i.global_irq_enable |=> irq_req_o[3])
        else $error("capture request dropped");
    a_sleep_cause: assert property ($rose(sleep_o)
        |-> $past(core_i.sleep_instr))
        else $error("sleep without instruction");
    a_wake_prompt: assert property ($past(sleep_o) && |irq_req_o
        |-> !sleep_o)
        else $error("no wake on request");
endmodule
`default_nettype wire

// *** tb/tfx_core_model.sv ***
// Core side model: executes the lowest pending vector when allowed.
// Assumes the block's requests are registered levels.
`timescale 1ns/1ps
`default_nettype none
module tfx_core_model
    import tfx_pkg::*;
(
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               en_i,
    input wire logic [NUM_VEC-1:0] irq_req_i,
    output logic                   ack_o,
    output tfx_vec_t               vec_o
);
    // one ack per request, never two in a row
    always_ff @(posedge clk_i) begin
        ack_o <= !rst_i && !ack_o && en_i && (|irq_req_i);
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (irq_req_i[i]) vec_o <= tfx_vec_t'(i);
        end
    end
endmodule
`default_nettype wire

// *** tb/test_timer_flags_ext_irq_sense.sv ***
// Self-checking bench for the timer flag and pin sense block.
// Assumes the core model file and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_timer_flags_ext_irq_sense import tfx_pkg::*; ;
    logic          clk_i, rst_i, psel, penable, pwrite, ack_en, gie, slp;
    logic          pready, perr, ack, sleep;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic [2:0]    pins;
    logic [8:0]    irq;
    tfx_timer_in_t tmr;
    tfx_core_in_t  core;
    tfx_vec_t      vec;
    tfx_sleep_t    smode;
    int            n_errors, comparisons;
    localparam logic [11:0] CTL = {IDX_MCU_CONTROL, 2'h0};
    localparam logic [11:0] FLG = {IDX_TIMER_FLAGS, 2'h0};
    assign core = {gie, ack, vec, slp};
    tfx_irq_sense i_tfx_irq_sense (.clk_i(clk_i), .rst_i(rst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
        .timer_i(tmr), .core_i(core), .ext_irq_pin_i(pins),
        .irq_req_o(irq), .sleep_o(sleep), .sleep_mode_o(smode));
    tfx_core_model i_tfx_core_model (.clk_i(clk_i), .rst_i(rst_i),
        .en_i(ack_en), .irq_req_i(irq), .ack_o(ack), .vec_o(vec));
    initial begin
        clk_i = 0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        int n;
        n = 0;
        @(posedge clk_i);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (!pready && ++n < 50);
        if (n >= 50) chk("ready", 0, 1);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic pulse_slp();
        @(posedge clk_i) slp <= 1'b1;
        @(posedge clk_i) slp <= 1'b0;
        tick(1);
    endtask
    task automatic test_done();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic test_regs_sleep();
        apb(0, CTL, 0); chk("ctl reset", rd, 0);
        apb(1, CTL, 'hFF); apb(0, CTL, 0); chk("ctl rw", rd, 'hFF);
        apb(0, 12'h0DD, 0); chk("misaligned", perr, 1);
        apb(1, CTL, 'h20); pulse_slp(); chk("no sleep", sleep, 0);
        // enable set just before the instruction
        apb(1, CTL, 'hA0); pulse_slp(); chk("sleep", sleep, 1);
        chk("mode", smode, SLP_POWER_DOWN);
        $display("test regs_sleep done");
    endtask
    task automatic test_capture();
        gie <= 1'b1;
        apb(1, {IDX_TIMER_MASK, 2'h0}, 'h3F);
        @(posedge clk_i) {tmr.wide_count, tmr.capture_evt} <= 17'h02469;
        @(posedge clk_i) tmr.capture_evt <= 1'b0;
        tick(1); chk("cap req", irq, 9'h008);
        chk("wake", sleep, 0);
        apb(0, FLG, 0); chk("cap flag", rd, 'h20);
        apb(0, {IDX_CAPTURE, 2'h0}, 0); chk("cap val", rd, 'h1234);
        ack_en <= 1'b1; tick(3); ack_en <= 1'b0;
        chk("acked", irq, 0);
        apb(0, FLG, 0); chk("flag acked", rd, 0);
        $display("test capture done");
    endtask
    task automatic test_flags();
        logic [7:0] ex[4] = '{8'h18, 8'h04, 8'h02, 8'h01};
        tmr.wide_count <= 16'h0000;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i) {gie, tmr.wide_tick, tmr.wide_overflow,
                tmr.narrow_tick, tmr.narrow_overflow} <= {i[0], 4'h8 >> i};
            @(posedge clk_i) {tmr.wide_tick, tmr.wide_overflow,
                tmr.narrow_tick, tmr.narrow_overflow} <= 4'h0;
            apb(0, FLG, 0); chk("flag set", rd, ex[i]);
            chk("gie gate", irq, {i == 3, 1'b0, i == 1, 6'h00});
            apb(1, FLG, ex[i]); apb(0, FLG, 0); chk("w1c", rd, 0);
        end
        $display("test flags done");
    endtask
    task automatic test_ext();
        gie <= 1'b1;
        apb(1, {IDX_EXT_CONTROL, 2'h0}, 'hE0);
        apb(1, CTL, 'h02);
        pins <= 3'b010; tick(6); chk("fall", irq[2:0], 5);
        // low level held far beyond one instruction
        pins <= 3'b000; tick(6); chk("level", irq[2:0], 7);
        pins <= 3'b010; tick(6); chk("level off", irq[2:0], 5);
        $display("test ext done");
    endtask
    initial begin
        {tmr, psel, penable, pwrite, paddr, pwdata, ack_en, gie, slp} = '0;
        {pins, rst_i, n_errors, comparisons} = {3'h7, 1'b1, 64'h0};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        tick(4);
        test_regs_sleep();
        test_capture();
        test_flags();
        test_ext();
        test_done();
    end
    initial begin
        #2000000;
        n_errors++;
        test_done();
    end
endmodule
bind tfx_irq_sense tfx_irq_sense_chk i_tfx_irq_sense_chk (.clk_i, .rst_i,
    .psel_i, .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
    .timer_i, .core_i, .irq_req_o, .sleep_o);
`default_nettype wire
